/* tb/sbwm_ctrl_model.sv */
// Memory controller model driving commands and write beats into the core.
// Assumes the bench calls issue once per cycle; beats trail their command.
`timescale 1ns/100ps
`default_nettype none
`include "sbwm_consts.svh"
module sbwm_ctrl_model (
  // Clock
  input wire logic i_sys_clk,
  // Command toward the device
  output logic o_strobe_n,
  output logic o_rw_sel,
  output logic [`SBWM_ADDR_W-1:0] o_addr,
  // Write beats toward the device
  output logic [`SBWM_WORD_W-1:0] o_wd_pos,
  output logic [`SBWM_LANES-1:0] o_m_pos,
  output logic [`SBWM_WORD_W-1:0] o_wd_neg,
  output logic [`SBWM_LANES-1:0] o_m_neg
);
  logic pend = 1'b0;
  logic [`SBWM_WORD_W-1:0] pd0, pd1;
  logic [`SBWM_LANES-1:0] pm0, pm1;
  // Idle bus at time zero, nothing launched
  initial begin
    o_strobe_n = 1'b1;
    o_rw_sel = 1'b0;
    o_addr = 6'h00;
    o_wd_pos = 36'h000000000;
    o_wd_neg = 36'h000000000;
    o_m_pos = 4'hF;
    o_m_neg = 4'hF;
  end
  // One command per falling edge; beats of the previous write ride along
  task issue(input logic s_n, input logic rw, input logic [5:0] a, input logic [35:0] d0,
             input logic [3:0] m0, input logic [35:0] d1, input logic [3:0] m1);
    @(negedge i_sys_clk);
    o_strobe_n = s_n;
    o_rw_sel = rw;
    // Released address toggles so a stale value never looks valid
    o_addr = s_n ? ~o_addr : a;
    if (pend) begin
      o_wd_pos = pd0;
      o_m_pos = pm0;
      o_wd_neg = pd1;
      o_m_neg = pm1;
    end else begin
      o_wd_pos = ~o_wd_pos;
      o_wd_neg = ~o_wd_neg;
      o_m_pos = ~o_m_pos;
      o_m_neg = ~o_m_neg;
    end
    pend = !s_n && !rw;
    pd0 = d0;
    pd1 = d1;
    pm0 = m0;
    pm1 = m1;
  endtask : issue
endmodule : sbwm_ctrl_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the write-mask core against a shadow array.
// Assumes the controller model and core share one 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk;
  logic rst_n;
  logic strobe_n, rw_sel, wr_ready, oe_n;
  logic [5:0] addr;
  logic [35:0] wd_pos, wd_neg, dq_pos, dq_neg;
  logic [3:0] m_pos, m_neg;
  int err_count = 0;
  int tests_run = 0;
  logic clk_run = 1'b1;
  logic [35:0] shadow [64];
  logic v0 = 1'b0;
  logic v1 = 1'b0;
  logic [35:0] e0a, e0b, e1a, e1b;
  logic [3:0] tab [8] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'hF, 4'h0, 4'h3};
  // Clock and reset
  initial begin
    clk = 1'b0;
    // A stopped clock parks high for the quickest restart
    forever #4 clk = clk_run ? ~clk : 1'b1;
  end
  sbwm_ctrl_model sbwm_ctrl_model_i (.i_sys_clk(clk), .o_strobe_n(strobe_n), .o_rw_sel(rw_sel),
    .o_addr(addr), .o_wd_pos(wd_pos), .o_m_pos(m_pos), .o_wd_neg(wd_neg), .o_m_neg(m_neg));
  sbwm_core sbwm_core_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_transaction_strobe_n(strobe_n),
    .i_rw_sel(rw_sel), .i_addr(addr), .i_wdata_pos(wd_pos), .i_byte_lane_write_select_n_pos(m_pos),
    .i_wdata_neg(wd_neg), .i_byte_lane_write_select_n_neg(m_neg), .o_wr_ready(wr_ready),
    .o_dq_pos(dq_pos), .o_dq_neg(dq_neg), .o_dq_oe_n(oe_n));
  task check(input logic [35:0] seen, input logic [35:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d, input logic [3:0] m);
    logic [35:0] r;
    r = old;
    for (int g = 0; g < 4; g++) begin
      if (!m[g]) r[9*g +: 9] = d[9*g +: 9];
    end
    return r;
  endfunction : merge
  // Read launch pipeline; expectations taken from the shadow at launch
  always @(posedge clk) begin
    v0 <= rst_n && strobe_n === 1'b0 && rw_sel === 1'b1;
    v1 <= v0;
    e0a <= shadow[addr];
    e0b <= shadow[addr + 6'h01];
    e1a <= e0a;
    e1b <= e0b;
  end
  // Output enable and read beats judged mid-cycle, where they are settled
  always @(negedge clk) begin
    if (rst_n) begin
      check({35'h0, oe_n}, {35'h0, !v1}, "output enable");
      if (v1) begin
        check(dq_pos, e1a, "beat at A");
        check(dq_neg, e1b, "beat at A+1");
      end
    end
  end
  task wr(input logic [5:0] a, input logic [35:0] d0, input logic [3:0] m0,
          input logic [35:0] d1, input logic [3:0] m1);
    sbwm_ctrl_model_i.issue(1'b0, 1'b0, a, d0, m0, d1, m1);
    shadow[a] = merge(shadow[a], d0, m0);
    shadow[a + 6'h01] = merge(shadow[a + 6'h01], d1, m1);
  endtask : wr
  task rd(input logic [5:0] a);
    sbwm_ctrl_model_i.issue(1'b0, 1'b1, a, 36'h0, 4'hF, 36'h0, 4'hF);
  endtask : rd
  task nop(input int n, input logic rw);
    repeat (n) sbwm_ctrl_model_i.issue(1'b1, rw, 6'h00, 36'h0, 4'hF, 36'h0, 4'hF);
  endtask : nop
  // Idle state after reset, then no-ops of both polarities of select
  task t_reset;
    check({35'h0, oe_n}, 36'h000000001, "oe after reset");
    check({35'h0, wr_ready}, 36'h000000001, "ready after reset");
    nop(3, 1'b1);
    nop(3, 1'b0);
    $display("test reset done");
  endtask : t_reset
  // Lane patterns, different on each beat, over a known base word
  task t_lanes;
    for (int i = 0; i < 8; i++) begin
      wr(6'h0A, 36'h5A5A5A5A5, 4'h0, 36'hA5A5A5A5A, 4'h0);
      nop(6, 1'b0);
      wr(6'h0A, 36'h123456789, tab[i], 36'hFEDCBA987, tab[7 - i]);
      nop(6, 1'b0);
      rd(6'h0A);
      nop(3, 1'b0);
    end
    $display("test lanes done");
  endtask : t_lanes
  // Back-to-back writes across the address wrap, then back-to-back reads
  task t_b2b;
    for (int i = 0; i < 5; i++) begin
      check({35'h0, wr_ready}, 36'h000000001, "ready before push");
      wr(6'h3D + 6'(2 * i), 36'h00000F000 + 36'(i), 4'h0, 36'h0000000F0 + 36'(i), 4'h0);
    end
    nop(8, 1'b0);
    for (int i = 0; i < 5; i++) rd(6'h3D + 6'(2 * i));
    nop(3, 1'b0);
    $display("test back to back done");
  endtask : t_b2b
  // Read right behind a write stalls the commit; both must still land
  task t_stall;
    wr(6'h20, 36'h0F0F0F0F0, 4'h0, 36'h3C3C3C3C3, 4'h0);
    rd(6'h0A);
    nop(4, 1'b0);
    rd(6'h20);
    nop(3, 1'b0);
    $display("test stall done");
  endtask : t_stall
  // Clock parked high for a while, then a stored burst read back
  task t_park;
    @(negedge clk);
    clk_run = 1'b0;
    #40;
    check({35'h0, clk}, 36'h000000001, "clock parked high");
    check({35'h0, oe_n}, 36'h000000001, "bus idle while stopped");
    clk_run = 1'b1;
    rd(6'h0A);
    nop(3, 1'b0);
    $display("test park done");
  endtask : t_park
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // Watchdog sized well beyond the few hundred cycles of the tests
  initial begin
    #(8 * 4000);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_lanes;
    t_b2b;
    t_stall;
    t_park;
    complete_run;
  end
endmodule : testbench
`default_nettype wire

/* verilog/sbwm_consts.svh */
// Constants for the burst SRAM byte-lane write-mask block.
// Assumes one system clock; included by the package, the core and the controller model.
// What this block does
// [RQ1] 18-bit: select 0 gates bits 8:0, select 1 gates 17:9.
// [RQ2] 18-bit: both selects high, that beat writes nothing.
// [RQ3] 36-bit: four selects gate bits 8:0, 17:9, 26:18, 35:27.
// [RQ4] 36-bit: all selects low stores the whole 36-bit beat.
// [RQ5] 36-bit: all selects high leaves the location unchanged.
// [RQ6] Each beat's selects are honoured on their own, beat by beat.
// [RQ7] Write data taken on both clock rises, read data launched on both.
// [RQ8] After power-up the device is deselected, data outputs high impedance.
// [RQ9] Beat one targets the latched address, beat two that address plus one.
// [RQ10] Cycle t launches; beats placed at t+1 (write) and t+2 (read).
// [RQ11] Controller should park both input clocks high when stopping them.
// [RQ12] Write: select low, strobe low at t; beats follow at t+1.
// [RQ13] Read: select high, strobe low; strobe high is a no-op, bus high-Z.
// [RQ14] Selects stored with beat data, applied as lane merge mask at commit.
`ifndef SBWM_CONSTS_SVH
`define SBWM_CONSTS_SVH
`define SBWM_LANES 4
`define SBWM_LANE_W 9
`define SBWM_WORD_W 36
`define SBWM_ADDR_W 6
`define SBWM_FIFO_DEPTH 8
`define SBWM_READ_LAT 2
`endif

/* verilog/sbwm_core.sv */
// Write-mask core of a two-beat burst SRAM, 36-bit organisation.
// Assumes the controller runs on i_sys_clk; one cycle is one input clock
// period, the positive-edge and negative-edge beats travel side by side.
`timescale 1ns/100ps
`default_nettype none
`include "sbwm_consts.svh"
module sbwm_core (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Command, sampled at the positive rise of cycle t
  input wire logic i_transaction_strobe_n,
  input wire logic i_rw_sel,
  input wire logic [`SBWM_ADDR_W-1:0] i_addr,
  // Write beats in cycle t+1
  input wire logic [`SBWM_WORD_W-1:0] i_wdata_pos,
  input wire logic [`SBWM_LANES-1:0] i_byte_lane_write_select_n_pos,
  input wire logic [`SBWM_WORD_W-1:0] i_wdata_neg,
  input wire logic [`SBWM_LANES-1:0] i_byte_lane_write_select_n_neg,
  output logic o_wr_ready,
  // Read beats in cycle t+2
  output logic [`SBWM_WORD_W-1:0] o_dq_pos,
  output logic [`SBWM_WORD_W-1:0] o_dq_neg,
  output logic o_dq_oe_n
);
  sbwm_pkg::sbwm_state_e state_q;
  sbwm_pkg::sbwm_state_e state_d;
  sbwm_pkg::sbwm_addr_t addr_q;
  sbwm_pkg::sbwm_burst_s push_burst;
  sbwm_pkg::sbwm_burst_s pop_burst;
  sbwm_pkg::sbwm_mask_t mask_pos;
  sbwm_pkg::sbwm_mask_t mask_neg;
  sbwm_pkg::sbwm_addr_t rd_a1;
  sbwm_pkg::sbwm_addr_t wr_a1;
  logic push_valid;
  logic fifo_in_ready;
  logic pop_valid;
  logic pop_ready;
  logic commit;
  logic oe_n_q;

  // Launch decode at the positive rise of cycle t
  always_comb begin
    if (i_transaction_strobe_n) begin
      state_d = sbwm_pkg::SBWM_IDLE; // [RQ13]
    end else if (i_rw_sel) begin
      state_d = sbwm_pkg::SBWM_RD; // [RQ13]
    end else begin
      state_d = sbwm_pkg::SBWM_WR; // [RQ12]
    end
  end

  // Launch state; power-up lands deselected
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= sbwm_pkg::SBWM_IDLE; // [RQ8]
    end else begin
      state_q <= state_d; // [RQ10]
    end
  end

  // Address latched with the launch, kept for both beats
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      addr_q <= '0;
    end else if (!i_transaction_strobe_n) begin
      addr_q <= i_addr; // [RQ9]
    end
  end

  // Active-low selects become per-beat store masks, one lane per bit.
  // The 18-bit organisation uses lanes 0 and 1 only; its controller
  // holds selects 2 and 3 high, so those lanes never store.
  for (genvar g = 0; g < `SBWM_LANES; g++) begin : g_mask
    assign mask_pos[g] = ~i_byte_lane_write_select_n_pos[g]; // [RQ1] [RQ3]
    assign mask_neg[g] = ~i_byte_lane_write_select_n_neg[g]; // [RQ6]
  end

  // Both beats and their masks enter the write data buffer at t+1
  always_comb begin
    push_burst.addr = addr_q;
    push_burst.d0 = i_wdata_pos; // [RQ7]
    push_burst.m0 = mask_pos; // [RQ14]
    push_burst.d1 = i_wdata_neg; // [RQ7]
    push_burst.m1 = mask_neg; // [RQ14]
  end
  assign push_valid = (state_q == sbwm_pkg::SBWM_WR); // [RQ12]
  // Controller must hold off new writes while this is low
  assign o_wr_ready = fifo_in_ready;

  // Eight bursts deep; commits drain one per cycle, so it only backs
  // up while reads keep stalling the commit.
  sbwm_fifo #(
    .W($bits(sbwm_pkg::sbwm_burst_s)),
    .DEPTH(`SBWM_FIFO_DEPTH)
  ) u_wbuf (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(push_burst),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_burst)
  );

  // Commit stalls in a read's issue cycle; keeps array access simple
  // at the cost of a read seeing only already committed bursts.
  assign pop_ready = (state_q != sbwm_pkg::SBWM_RD);
  assign commit = pop_valid & pop_ready;
  assign wr_a1 = pop_burst.addr + 1'b1; // [RQ9]
  assign rd_a1 = addr_q + 1'b1; // [RQ9]

  // Masks gate each lane; all-high beats write nothing at all
  sbwm_mem #(
    .AW(`SBWM_ADDR_W),
    .LANES(`SBWM_LANES),
    .LW(`SBWM_LANE_W)
  ) u_array (
    .i_sys_clk(i_sys_clk),
    .i_we(commit), // [RQ14] [RQ2] [RQ5]
    .i_wa0(pop_burst.addr),
    .i_wa1(wr_a1),
    .i_wd0(pop_burst.d0),
    .i_wd1(pop_burst.d1),
    .i_wm0(pop_burst.m0), // [RQ4]
    .i_wm1(pop_burst.m1),
    .i_ra0(addr_q),
    .i_ra1(rd_a1),
    .o_rd0(o_dq_pos), // [RQ7]
    .o_rd1(o_dq_neg)
  );

  // Bus driven only in t+2 of a read, else high impedance
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      oe_n_q <= 1'b1; // [RQ8]
    end else begin
      oe_n_q <= (state_q != sbwm_pkg::SBWM_RD); // [RQ10] [RQ13]
    end
  end
  assign o_dq_oe_n = oe_n_q;

  // Checks on launch placement, masking and addressing

  property p_power_up_hiz;
    @(posedge i_sys_clk) !i_rst_n |=> o_dq_oe_n;
  endproperty
  a_power_up_hiz: assert property (p_power_up_hiz) // [RQ8]
    else $error("bus not released after reset");

  property p_read_at_t2;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_transaction_strobe_n && i_rw_sel) |-> ##`SBWM_READ_LAT !o_dq_oe_n;
  endproperty
  a_read_at_t2: assert property (p_read_at_t2) // [RQ10]
    else $error("read data not driven at t+2");

  property p_nop_hiz;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_transaction_strobe_n ##1 1'b1) |-> ##1 o_dq_oe_n;
  endproperty
  a_nop_hiz: assert property (p_nop_hiz) // [RQ13]
    else $error("bus driven after no-operation");

  property p_write_beats_t1;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_transaction_strobe_n && !i_rw_sel) |=> push_valid && o_dq_oe_n;
  endproperty
  a_write_beats_t1: assert property (p_write_beats_t1) // [RQ12]
    else $error("write beats not taken at t+1");

  property p_lane_masks;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      push_valid |-> (push_burst.m0 == ~i_byte_lane_write_select_n_pos)
        && (push_burst.m1 == ~i_byte_lane_write_select_n_neg);
  endproperty
  a_lane_masks: assert property (p_lane_masks) // [RQ6]
    else $error("beat masks do not follow their own selects");

  property p_all_high_none;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (push_valid && (&i_byte_lane_write_select_n_pos)) |-> push_burst.m0 == '0;
  endproperty
  a_all_high_none: assert property (p_all_high_none) // [RQ5]
    else $error("lane stored with all selects high");

  property p_all_low_full;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (push_valid && !(|i_byte_lane_write_select_n_neg)) |-> &push_burst.m1;
  endproperty
  a_all_low_full: assert property (p_all_low_full) // [RQ4]
    else $error("full-word write lost a lane");

  property p_lane0_low_only;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (push_valid && i_byte_lane_write_select_n_pos == 4'hE)
        |-> push_burst.m0 == 4'h1;
  endproperty
  a_lane0_low_only: assert property (p_lane0_low_only) // [RQ1] [RQ3]
    else $error("lane 0 only write touched other lanes");

  property p_burst_addr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_transaction_strobe_n ##1 state_q == sbwm_pkg::SBWM_RD)
        |-> (addr_q == $past(i_addr)) && (rd_a1 == addr_q + 1'b1);
  endproperty
  a_burst_addr: assert property (p_burst_addr) // [RQ9]
    else $error("burst address sequence wrong");

  property p_commit_masked;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      push_valid && fifo_in_ready && !pop_valid && pop_ready && state_d != sbwm_pkg::SBWM_RD
        |=> commit && pop_burst.m0 == $past(mask_pos);
  endproperty
  a_commit_masked: assert property (p_commit_masked) // [RQ14]
    else $error("buffered masks not applied at commit");

  // A stalled head burst must not change under the stall
  property p_stall_holds_head;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      pop_valid && !pop_ready |=> $stable(pop_burst);
  endproperty
  a_stall_holds_head: assert property (p_stall_holds_head) // [RQ14]
    else $error("buffered burst changed while stalled");

  // No commit may touch the array in a read's issue cycle
  property p_read_stalls_commit;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      state_q == sbwm_pkg::SBWM_RD |-> !commit;
  endproperty
  a_read_stalls_commit: assert property (p_read_stalls_commit) // [RQ14]
    else $error("commit collided with read issue");

  // Bus released after any cycle without a read issue
  property p_release_after_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      state_q != sbwm_pkg::SBWM_RD |=> o_dq_oe_n;
  endproperty
  a_release_after_read: assert property (p_release_after_read) // [RQ13]
    else $error("bus held after read completed");

  // Second beat of a burst at the top address wraps to zero
  property p_addr_wrap;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      commit && (&pop_burst.addr) |-> wr_a1 == '0;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) // [RQ9]
    else $error("burst address did not wrap");

  // Latched address survives idle cycles untouched
  property p_addr_held;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_transaction_strobe_n |=> $stable(addr_q);
  endproperty
  a_addr_held: assert property (p_addr_held) // [RQ9]
    else $error("latched address moved without a launch");

  // Buffer empty and able to take bursts straight after reset
  property p_ready_after_reset;
    @(posedge i_sys_clk) !i_rst_n |=> o_wr_ready;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) // [RQ8]
    else $error("write buffer not ready after reset");

  // Only a write launch may push a burst into the buffer
  property p_push_only_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      push_valid |-> $past(!i_transaction_strobe_n && !i_rw_sel);
  endproperty
  a_push_only_write: assert property (p_push_only_write) // [RQ12]
    else $error("burst pushed without a write launch");

  // Both low-lane selects high on the second beat: the 18-bit word stores nothing
  property p_low_pair_none;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (push_valid && (&i_byte_lane_write_select_n_neg[1:0])) |-> push_burst.m1[1:0] == 2'h0;
  endproperty
  a_low_pair_none: assert property (p_low_pair_none) // [RQ2]
    else $error("18-bit beat stored with both selects high");

  // A taken push leaves the buffer holding a burst for commit
  property p_push_kept;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      push_valid && fifo_in_ready |=> pop_valid;
  endproperty
  a_push_kept: assert property (p_push_kept) // [RQ7]
    else $error("pushed burst lost from the buffer");

  // Main scenarios
  c_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    push_valid && i_byte_lane_write_select_n_pos != i_byte_lane_write_select_n_neg);
  c_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_dq_oe_n);
  c_full: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !fifo_in_ready);
  c_stall: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pop_valid && !pop_ready);
  c_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    commit && (&pop_burst.addr));
endmodule : sbwm_core
`default_nettype wire

/* verilog/sbwm_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sbwm_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign o_in_ready = (count_q != (PW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_q[rd_ptr_q];

  // Storage, written only on a taken push
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : sbwm_fifo
`default_nettype wire

/* verilog/sbwm_mem.sv */
// Lane-split array: two masked write ports, two registered read ports.
// Assumes the two write addresses never coincide in one cycle.
`timescale 1ns/100ps
`default_nettype none
module sbwm_mem #(
  parameter int AW = 6,
  parameter int LANES = 4,
  parameter int LW = 9
) (
  // Clock
  input wire logic i_sys_clk,
  // Burst commit
  input wire logic i_we,
  input wire logic [AW-1:0] i_wa0,
  input wire logic [AW-1:0] i_wa1,
  input wire logic [LANES*LW-1:0] i_wd0,
  input wire logic [LANES*LW-1:0] i_wd1,
  input wire logic [LANES-1:0] i_wm0,
  input wire logic [LANES-1:0] i_wm1,
  // Burst read
  input wire logic [AW-1:0] i_ra0,
  input wire logic [AW-1:0] i_ra1,
  output logic [LANES*LW-1:0] o_rd0,
  output logic [LANES*LW-1:0] o_rd1
);
  // One array per lane, so a lane held off keeps its old contents
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LW-1:0] lane_q [2**AW];
    always_ff @(posedge i_sys_clk) begin
      if (i_we && i_wm0[g]) begin
        lane_q[i_wa0] <= i_wd0[g*LW +: LW];
      end
      if (i_we && i_wm1[g]) begin
        lane_q[i_wa1] <= i_wd1[g*LW +: LW];
      end
      o_rd0[g*LW +: LW] <= lane_q[i_ra0];
      o_rd1[g*LW +: LW] <= lane_q[i_ra1];
    end
  end
endmodule : sbwm_mem
`default_nettype wire

/* verilog/sbwm_pkg.sv */
// Types shared by the write-mask block and its helpers.
// Assumes sbwm_consts.svh is on the include path.
`include "sbwm_consts.svh"
package sbwm_pkg;
  typedef logic [`SBWM_ADDR_W-1:0] sbwm_addr_t;
  typedef logic [`SBWM_WORD_W-1:0] sbwm_word_t;
  typedef logic [`SBWM_LANES-1:0] sbwm_mask_t;
  // One buffered burst: address, two beats, per-beat lane masks
  typedef struct packed {
    sbwm_addr_t addr;
    sbwm_word_t d0;
    sbwm_mask_t m0;
    sbwm_word_t d1;
    sbwm_mask_t m1;
  } sbwm_burst_s;
  // What the previous rising edge launched
  typedef enum logic [1:0] {
    SBWM_IDLE = 2'b00,
    SBWM_WR = 2'b01,
    SBWM_RD = 2'b11
  } sbwm_state_e;
endpackage : sbwm_pkg
